// ==== ffl_defines.svh ====
// Constants for the serial offset loader: widths, sizes, reset values, timing.
// Assumes both ends include this header and share one clock.
`ifndef FFL_DEFINES_SVH
`define FFL_DEFINES_SVH
`define FFL_DW        18
`define FFL_OFF_W     17
`define FFL_MEM_AW    4
`define FFL_MEM_DEPTH 5'h10
`define FFL_BASE_X9   5'h0A
`define FFL_BASE_OTH  5'h09
`define FFL_DEF_OFF   17'h0007F
`define FFL_FLAG_DLY  2'h2
`endif

// ==== ffl_pkg.sv ====
// Types shared by both ends of the offset loader link.
// Assumes ffl_defines.svh is on the include path.
`include "ffl_defines.svh"
package ffl_pkg;
  // Controller action, one per cycle, one-hot
  typedef enum logic [5:0] {
    ACT_IDLE  = 6'h01,
    ACT_MRST  = 6'h02,
    ACT_WR    = 6'h04,
    ACT_SHIFT = 6'h08,
    ACT_RD    = 6'h10,
    ACT_ORD   = 6'h20
  } ffl_act_t;

  // Significant bits of one offset for a width mode and depth step
  function automatic logic [4:0] off_bits(input logic x9, input logic [2:0] depth);
    off_bits = (x9 ? `FFL_BASE_X9 : `FFL_BASE_OTH) + {2'h0, depth};
  endfunction : off_bits
endpackage : ffl_pkg

// ==== ffl_link_if.sv ====
// Link between the offset-loader controller and the FIFO device end.
// Assumes both ends run on the same clock; all signals are plain logic.
`timescale 1ns/100ps
`include "ffl_defines.svh"
interface ffl_link_if;
  logic                 load_select_n;           // Low steers strobes to offsets
  logic                 serial_shift_enable_n;   // Low enables serial shift
  logic                 write_enable_n;          // Low writes
  logic                 read_enable_n;           // Low reads
  logic                 serial_in;               // Serial offset bit
  logic [`FFL_DW-1:0]   data_in_bus;             // Memory write word
  logic                 master_reset;            // Sync master reset, high
  logic                 serial_prog_sel;         // Serial programming method
  logic                 width_x9_x9;             // Both ports nine bits
  logic [2:0]           depth_sel;               // Depth step 0..7
  logic                 first_word_fall_through; // Timing mode
  logic [`FFL_DW-1:0]   data_out;                // Read word
  logic                 data_out_valid;          // Read word pulse
  logic                 write_ready;             // Write buffer has room
  logic                 prog_almost_empty_flag_n; // Almost empty, low
  logic                 prog_almost_full_flag_n;  // Almost full, low
  logic                 flags_valid;             // Offsets loaded, flags good

  modport dev (
    input  load_select_n, serial_shift_enable_n, write_enable_n, read_enable_n,
    input  serial_in, data_in_bus, master_reset, serial_prog_sel, width_x9_x9,
    input  depth_sel, first_word_fall_through,
    output data_out, data_out_valid, write_ready, prog_almost_empty_flag_n,
    output prog_almost_full_flag_n, flags_valid
  );
  modport ctl (
    output load_select_n, serial_shift_enable_n, write_enable_n, read_enable_n,
    output serial_in, data_in_bus, master_reset, serial_prog_sel, width_x9_x9,
    output depth_sel, first_word_fall_through,
    input  data_out, data_out_valid, write_ready, prog_almost_empty_flag_n,
    input  prog_almost_full_flag_n, flags_valid
  );
endinterface : ffl_link_if

// ==== ffl_device_end.sv ====
// FIFO device end: serial offset loader, strobe decode, small memory, flags.
// Assumes the controller end drives the link from flops on the same i_clk.
`timescale 1ns/100ps
`include "ffl_defines.svh"
// Function
// RULE1: both load controls low, enables high: shift
// RULE2: nine-to-nine load takes 20 to 34 bits
// RULE3: wider modes need two fewer bits
// RULE4: serial enable high blocks every shift
// RULE5: method latched only during master reset
// RULE6: parallel offset readback in either method
// RULE7: timing mode never alters programming
// RULE8: only a full bit set reprograms
// RULE9: memory writes allowed before and during load
// RULE10: both controls high: write memory, then resume
// RULE11: pause keeps bit position, resume later
// RULE12: flags invalid in load, valid two edges after
// RULE13: no serial readback; parallel only
// RULE14: offset width 10..17, one less otherwise
// RULE15: load select high: enables access memory
module ffl_device_end (
  input  wire logic             i_clk,        // System clock
  input  wire logic             i_rst,        // Async reset, high
  ffl_link_if.dev               lnk,          // Link to controller
  output logic [`FFL_OFF_W-1:0] o_empty_off,  // Empty offset register
  output logic [`FFL_OFF_W-1:0] o_full_off,   // Full offset register
  output logic [4:0]            o_mem_count,  // Words held in memory
  output logic                  o_serial_mode, // Latched method
  output logic                  o_first_word_fall_through_mode   // Latched timing mode
);
  // Latched configuration
  logic                  serial_ff;     // Serial method chosen
  logic                  x9_ff;         // Nine-to-nine mode
  logic [2:0]            depth_ff;      // Depth step
  logic                  first_word_fall_through_ff;       // Timing mode, no effect on loading
  // Offset loader state
  logic [`FFL_OFF_W-1:0] empty_off_ff;  // Almost-empty offset
  logic [`FFL_OFF_W-1:0] full_off_ff;   // Almost-full offset
  logic [`FFL_OFF_W-1:0] nxt_empty_off; // Next empty offset
  logic [`FFL_OFF_W-1:0] nxt_full_off;  // Next full offset
  logic [5:0]            bit_ptr_ff;    // Next bit position in the set
  logic                  loaded_ff;     // Full set entered
  logic [1:0]            dly_ff;        // Edges left before flags valid
  logic                  ord_ptr_ff;    // Readback pointer, 0 empty, 1 full
  // Write buffer, two entries
  logic [`FFL_DW-1:0]    buf_mem [2];   // Buffered words
  logic                  buf_wp_ff;     // Buffer write slot
  logic                  buf_rp_ff;     // Buffer read slot
  logic [1:0]            buf_cnt_ff;    // Buffered count
  // Memory
  logic [`FFL_DW-1:0]    mem [`FFL_MEM_DEPTH]; // Storage
  logic [`FFL_MEM_AW-1:0] mem_wp_ff;    // Memory write pointer
  logic [`FFL_MEM_AW-1:0] mem_rp_ff;    // Memory read pointer
  logic [4:0]            mem_cnt_ff;    // Memory count
  logic [`FFL_DW-1:0]    dout_ff;       // Read data register
  logic                  dout_vld_ff;   // Read data pulse

  // Strobe decode
  wire       ld_lo    = ~lnk.load_select_n;
  wire       sen_lo   = ~lnk.serial_shift_enable_n;
  wire       wen_lo   = ~lnk.write_enable_n;
  wire       ren_lo   = ~lnk.read_enable_n;
  wire [4:0] nbits    = ffl_pkg::off_bits(x9_ff, depth_ff);            // RULE14
  wire [5:0] total    = {nbits, 1'b0};                                   // RULE2 RULE3
  wire       shift_en = serial_ff & ld_lo & sen_lo & ~wen_lo & ~ren_lo &
                        ~lnk.master_reset;                               // RULE1 RULE4 RULE11
  wire       last_bit = shift_en & (bit_ptr_ff == total - 6'h01);        // RULE8
  wire       in_empty = bit_ptr_ff < {1'b0, nbits};
  wire [4:0] empty_ix = bit_ptr_ff[4:0];
  wire [4:0] full_ix  = bit_ptr_ff[4:0] - nbits;
  wire       wr_req   = ~ld_lo & wen_lo;                                 // RULE15 RULE10 RULE9
  wire       rd_req   = ~ld_lo & ren_lo;                                 // RULE15
  wire       ord_req  = ld_lo & ren_lo & ~wen_lo;                        // RULE6 RULE13
  wire       buf_rdy  = buf_cnt_ff != 2'h2;
  wire       buf_push = wr_req & buf_rdy & ~lnk.master_reset;
  wire       mem_full = mem_cnt_ff == `FFL_MEM_DEPTH;
  wire       mem_push = (buf_cnt_ff != 2'h0) & ~mem_full;
  wire       mem_pop  = rd_req & (mem_cnt_ff != 5'h00) & ~lnk.master_reset;
  wire       flags_ok = loaded_ff & (dly_ff == 2'h0);                    // RULE12
  wire [4:0] full_lim = `FFL_MEM_DEPTH - 5'h01;
  // Widths of offsets exceed the small memory; compare at offset width
  wire       ae_hit   = {12'h000, mem_cnt_ff} <= empty_off_ff;
  wire       af_hit   = {13'h0000, mem_cnt_ff} + {1'b0, full_off_ff} >= {13'h0000, full_lim} + 18'h00001;

  // Serial bit lands in the empty offset first, then the full offset
  always_comb begin
    nxt_empty_off = empty_off_ff;
    nxt_full_off  = full_off_ff;
    if (shift_en) begin                                                  // RULE1
      if (in_empty) begin
        nxt_empty_off[empty_ix] = lnk.serial_in;
      end else begin
        nxt_full_off[full_ix] = lnk.serial_in;
      end
    end
  end

  // Configuration is caught only while master reset is high
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      serial_ff <= 1'b1;
      x9_ff     <= 1'b1;
      depth_ff  <= 3'h0;
      first_word_fall_through_ff   <= 1'b0;
    end else if (lnk.master_reset) begin                                 // RULE5
      serial_ff <= lnk.serial_prog_sel;
      x9_ff     <= lnk.width_x9_x9;
      depth_ff  <= lnk.depth_sel;
      first_word_fall_through_ff   <= lnk.first_word_fall_through;
    end
  end

  // Offset registers and bit pointer; a pause simply holds the pointer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      empty_off_ff <= `FFL_DEF_OFF;
      full_off_ff  <= `FFL_DEF_OFF;
      bit_ptr_ff   <= 6'h00;
    end else if (lnk.master_reset) begin
      empty_off_ff <= `FFL_DEF_OFF;
      full_off_ff  <= `FFL_DEF_OFF;
      bit_ptr_ff   <= 6'h00;
    end else begin
      empty_off_ff <= nxt_empty_off;
      full_off_ff  <= nxt_full_off;
      if (last_bit) begin                                                // RULE8
        bit_ptr_ff <= 6'h00;
      end else if (shift_en) begin                                       // RULE11
        bit_ptr_ff <= bit_ptr_ff + 6'h01;
      end
    end
  end

  // Flags drop at any shift and return two edges after the last bit
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      loaded_ff <= 1'b1;
      dly_ff    <= 2'h0;
    end else if (lnk.master_reset) begin
      loaded_ff <= 1'b1;
      dly_ff    <= 2'h0;
    end else if (last_bit) begin                                         // RULE12
      loaded_ff <= 1'b1;
      dly_ff    <= `FFL_FLAG_DLY;
    end else if (shift_en) begin                                         // RULE8
      loaded_ff <= 1'b0;
    end else if (dly_ff != 2'h0) begin
      dly_ff <= dly_ff - 2'h1;
    end
  end

  // Write buffer absorbs writes while memory is full
  always_ff @(posedge i_clk) begin
    if (buf_push) begin
      buf_mem[buf_wp_ff] <= lnk.data_in_bus;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      buf_wp_ff  <= 1'b0;
      buf_rp_ff  <= 1'b0;
      buf_cnt_ff <= 2'h0;
    end else if (lnk.master_reset) begin
      buf_wp_ff  <= 1'b0;
      buf_rp_ff  <= 1'b0;
      buf_cnt_ff <= 2'h0;
    end else begin
      buf_wp_ff  <= buf_wp_ff ^ buf_push;
      buf_rp_ff  <= buf_rp_ff ^ mem_push;
      buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_push} - {1'b0, mem_push};
    end
  end

  // Memory array, no reset needed on storage
  always_ff @(posedge i_clk) begin
    if (mem_push) begin
      mem[mem_wp_ff] <= buf_mem[buf_rp_ff];
    end
  end

  // Memory pointers, read data and offset readback
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_wp_ff   <= '0;
      mem_rp_ff   <= '0;
      mem_cnt_ff  <= 5'h00;
      dout_ff     <= '0;
      dout_vld_ff <= 1'b0;
      ord_ptr_ff  <= 1'b0;
    end else if (lnk.master_reset) begin
      mem_wp_ff   <= '0;
      mem_rp_ff   <= '0;
      mem_cnt_ff  <= 5'h00;
      dout_vld_ff <= 1'b0;
      ord_ptr_ff  <= 1'b0;
    end else begin
      dout_vld_ff <= mem_pop | ord_req;
      if (mem_push) begin
        mem_wp_ff <= mem_wp_ff + 4'h1;
      end
      mem_cnt_ff <= mem_cnt_ff + {4'h0, mem_push} - {4'h0, mem_pop};
      if (mem_pop) begin                                                 // RULE15
        dout_ff   <= mem[mem_rp_ff];
        mem_rp_ff <= mem_rp_ff + 4'h1;
      end else if (ord_req) begin                                        // RULE6
        // Readback overwrites the word on the output, as a read would
        dout_ff    <= {1'b0, ord_ptr_ff ? full_off_ff : empty_off_ff};
        ord_ptr_ff <= ~ord_ptr_ff;
      end
    end
  end

  // Link outputs; invalid flags rest inactive high
  assign lnk.data_out                 = dout_ff;
  assign lnk.data_out_valid           = dout_vld_ff;
  assign lnk.write_ready              = buf_rdy;
  assign lnk.flags_valid              = flags_ok;                        // RULE12
  assign lnk.prog_almost_empty_flag_n = ~(flags_ok & ae_hit);
  assign lnk.prog_almost_full_flag_n  = ~(flags_ok & af_hit);
  assign o_empty_off                  = empty_off_ff;
  assign o_full_off                   = full_off_ff;
  assign o_mem_count                  = mem_cnt_ff;
  assign o_serial_mode                = serial_ff;
  assign o_first_word_fall_through_mode                  = first_word_fall_through_ff;                         // RULE7
endmodule : ffl_device_end

// ==== ffl_ctrl_end.sv ====
// Controller end: turns user commands into link strobes, one action per cycle.
// Assumes the device end samples the link on the same i_clk.
`timescale 1ns/100ps
`include "ffl_defines.svh"
module ffl_ctrl_end (
  input  wire logic                  i_clk,       // System clock
  input  wire logic                  i_rst,       // Async reset, high
  ffl_link_if.ctl                    lnk,         // Link to device
  input  wire logic                  i_mreset,    // Master reset request pulse
  input  wire logic                  i_serial_sel, // Method for next reset
  input  wire logic                  i_x9,        // Width mode for next reset
  input  wire logic [2:0]            i_depth,     // Depth for next reset
  input  wire logic                  i_first_word_fall_through,      // Timing mode for next reset
  input  wire logic                  i_load,      // Start serial load pulse
  input  wire logic [`FFL_OFF_W-1:0] i_empty_off, // New empty offset
  input  wire logic [`FFL_OFF_W-1:0] i_full_off,  // New full offset
  input  wire logic                  i_wr_valid,  // Write word offered
  input  wire logic [`FFL_DW-1:0]    i_wr_data,   // Write word
  output logic                       o_wr_ready,  // Write word taken
  input  wire logic                  i_rd,        // Memory read request pulse
  input  wire logic                  i_offrd,     // Offset readback pulse
  output logic [`FFL_DW-1:0]         o_rd_data,   // Read word
  output logic                       o_rd_valid,  // Read word pulse
  output logic                       o_busy,      // Serial load in progress
  output logic                       o_pae_n,     // Almost empty, low
  output logic                       o_paf_n      // Almost full, low
);
  ffl_pkg::ffl_act_t     act_ff;        // Action on the link now
  ffl_pkg::ffl_act_t     nxt_act;       // Action for next cycle
  logic [4:0]            cfg_ff;        // serial, x9, depth
  logic                  first_word_fall_through_ff;       // Timing mode
  logic [33:0]           sh_ff;         // Bits still to send, LSB first
  logic [5:0]            rem_ff;        // Count of bits still to send
  logic [`FFL_DW-1:0]    dat_ff;        // Word on the data bus
  logic                  rd_pend_ff;    // Memory read waiting for a slot
  logic                  ord_pend_ff;   // Offset read waiting for a slot
  logic [`FFL_DW-1:0]    rd_data_ff;    // Captured read word
  logic                  rd_vld_ff;     // Captured read pulse

  wire [4:0]  nbits   = ffl_pkg::off_bits(cfg_ff[3], cfg_ff[2:0]);
  // Empty offset in the low bits, full offset just above it
  wire [33:0] load_vec = {17'h00000, i_empty_off} |
                         ({17'h00000, i_full_off} << nbits);
  // One write in flight at most, so a ready seen here is still true
  wire        can_wr  = i_wr_valid & lnk.write_ready & (act_ff != ffl_pkg::ACT_WR);
  wire        shifting = rem_ff != 6'h00;

  // Priority: reset, write, serial bit, read, offset read
  always_comb begin
    nxt_act = ffl_pkg::ACT_IDLE;
    if (i_mreset) begin
      nxt_act = ffl_pkg::ACT_MRST;
    end else if (can_wr) begin
      nxt_act = ffl_pkg::ACT_WR;            // Memory write between serial bits
    end else if (shifting) begin
      nxt_act = ffl_pkg::ACT_SHIFT;
    end else if (rd_pend_ff | i_rd) begin
      nxt_act = ffl_pkg::ACT_RD;
    end else if (ord_pend_ff | i_offrd) begin
      nxt_act = ffl_pkg::ACT_ORD;
    end
  end

  // Action register and the words that go with it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      act_ff  <= ffl_pkg::ACT_IDLE;
      cfg_ff  <= 5'h18;
      first_word_fall_through_ff <= 1'b0;
      dat_ff  <= '0;
    end else begin
      act_ff <= nxt_act;
      if (i_mreset) begin
        cfg_ff  <= {i_serial_sel, i_x9, i_depth};
        first_word_fall_through_ff <= i_first_word_fall_through;
      end
      if (nxt_act == ffl_pkg::ACT_WR) begin
        dat_ff <= i_wr_data;
      end
    end
  end

  // Serial bit stream; a new load always sends the whole set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_ff  <= '0;
      rem_ff <= 6'h00;
    end else if (i_mreset) begin
      rem_ff <= 6'h00;
    end else if (i_load & ~shifting & (act_ff != ffl_pkg::ACT_SHIFT)) begin
      sh_ff  <= load_vec;
      rem_ff <= {nbits, 1'b0};
    end else begin
      if (nxt_act == ffl_pkg::ACT_SHIFT) begin
        rem_ff <= rem_ff - 6'h01;
      end
      if (act_ff == ffl_pkg::ACT_SHIFT) begin
        sh_ff <= {1'b0, sh_ff[33:1]};
      end
    end
  end

  // Pending reads and captured answers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_pend_ff  <= 1'b0;
      ord_pend_ff <= 1'b0;
      rd_data_ff  <= '0;
      rd_vld_ff   <= 1'b0;
    end else begin
      rd_pend_ff  <= (rd_pend_ff | i_rd) & (nxt_act != ffl_pkg::ACT_RD);
      ord_pend_ff <= (ord_pend_ff | i_offrd) & (nxt_act != ffl_pkg::ACT_ORD);
      rd_vld_ff   <= lnk.data_out_valid;
      if (lnk.data_out_valid) begin
        rd_data_ff <= lnk.data_out;
      end
    end
  end

  // Link strobes decoded from the registered action
  wire a_wr  = act_ff == ffl_pkg::ACT_WR;
  wire a_sh  = act_ff == ffl_pkg::ACT_SHIFT;
  wire a_rd  = act_ff == ffl_pkg::ACT_RD;
  wire a_ord = act_ff == ffl_pkg::ACT_ORD;
  assign lnk.load_select_n           = ~(a_sh | a_ord);
  assign lnk.serial_shift_enable_n   = ~a_sh;
  assign lnk.write_enable_n          = ~a_wr;
  assign lnk.read_enable_n           = ~(a_rd | a_ord);
  assign lnk.serial_in               = sh_ff[0];
  assign lnk.data_in_bus             = dat_ff;
  assign lnk.master_reset            = act_ff == ffl_pkg::ACT_MRST;
  assign lnk.serial_prog_sel         = cfg_ff[4];
  assign lnk.width_x9_x9             = cfg_ff[3];
  assign lnk.depth_sel               = cfg_ff[2:0];
  assign lnk.first_word_fall_through = first_word_fall_through_ff;
  assign o_wr_ready = (nxt_act == ffl_pkg::ACT_WR);
  assign o_rd_data  = rd_data_ff;
  assign o_rd_valid = rd_vld_ff;
  assign o_busy     = shifting | a_sh;
  assign o_pae_n    = lnk.prog_almost_empty_flag_n;
  assign o_paf_n    = lnk.prog_almost_full_flag_n;
endmodule : ffl_ctrl_end

// ==== ffl_link_sva.sv ====
// Checker for the offset loader link, fed the interface signals.
// Assumes one clock and a link driven from flops on its rising edge.
`timescale 1ns/100ps
module ffl_link_sva (
  input wire logic       i_clk,                    // Clock
  input wire logic       i_rst,                    // Async reset
  input wire logic       load_select_n,            // Offset access
  input wire logic       serial_shift_enable_n,    // Shift enable
  input wire logic       write_enable_n,           // Write strobe
  input wire logic       read_enable_n,            // Read strobe
  input wire logic       master_reset,             // Sync reset
  input wire logic       serial_prog_sel,          // Method
  input wire logic       width_x9_x9,              // Width mode
  input wire logic [2:0] depth_sel,                // Depth step
  input wire logic       data_out_valid,           // Read pulse
  input wire logic       prog_almost_empty_flag_n, // Almost empty
  input wire logic       prog_almost_full_flag_n,  // Almost full
  input wire logic       flags_valid               // Flags good
);
  logic       ser_ff; // Latched method
  logic       x9_ff;  // Latched width
  logic [2:0] dep_ff; // Latched depth
  logic [5:0] cnt_ff; // Bits taken since flags were valid
  wire        take = !load_select_n && !serial_shift_enable_n && write_enable_n && read_enable_n && ser_ff;
  wire  [5:0] tot  = (x9_ff ? 6'h14 : 6'h12) + {2'h0, dep_ff, 1'b0};
  // Mirror of the config; only master reset may change it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ser_ff <= 1'b1;
      x9_ff  <= 1'b1;
      dep_ff <= 3'h0;
    end else if (master_reset) begin
      ser_ff <= serial_prog_sel;
      x9_ff  <= width_x9_x9;
      dep_ff <= depth_sel;
    end
  end
  // Bit count; cleared once flags stand valid and idle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) cnt_ff <= 6'h00;
    else if (master_reset) cnt_ff <= 6'h00;
    else if (take) cnt_ff <= cnt_ff + 6'h01;
    else if (flags_valid) cnt_ff <= 6'h00;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Two edges of wait, then valid
  sequence s_settle;
    !flags_valid [*2] ##1 flags_valid;
  endsequence
  property p_drop; take |=> !flags_valid; endproperty
  property p_sen; !load_select_n && serial_shift_enable_n && flags_valid && !master_reset |=> flags_valid; endproperty
  property p_ren; !load_select_n && !read_enable_n && flags_valid && !master_reset |=> flags_valid; endproperty
  property p_total; take && cnt_ff == tot - 6'h01 |=> s_settle; endproperty
  property p_early; !flags_valid && cnt_ff < tot && !master_reset |=> !flags_valid; endproperty
  property p_idle; !flags_valid |-> prog_almost_empty_flag_n && prog_almost_full_flag_n; endproperty
  property p_cause; data_out_valid |-> !$past(read_enable_n); endproperty
  property p_offrd; !load_select_n && !read_enable_n && write_enable_n |=> data_out_valid; endproperty
  a_drop: assert property (p_drop) else $error("shift left flags valid");
  a_sen: assert property (p_sen) else $error("shift with enable high");
  a_ren: assert property (p_ren) else $error("shift during a read");
  a_total: assert property (p_total) else $error("flags not valid two edges after last bit");
  a_early: assert property (p_early) else $error("flags valid before full set");
  a_idle: assert property (p_idle) else $error("flag active while invalid");
  a_cause: assert property (p_cause) else $error("read word without strobe");
  a_offrd: assert property (p_offrd) else $error("offset readback missing");
endmodule : ffl_link_sva

// ==== tb.sv ====
// Testbench: controller and device ends face each other over the link.
// Assumes the design files and ffl_defines.svh compile first.
`timescale 1ns/100ps
`include "ffl_defines.svh"
module tb;
  logic        i_clk = 1'b0; // 10 MHz clock
  logic        i_rst = 1'b1; // Async reset
  logic        i_mreset, i_serial_sel, i_x9, i_first_word_fall_through, i_load, i_wr_valid, i_rd, i_offrd;
  logic [2:0]  i_depth;
  logic [16:0] i_empty_off, i_full_off, o_empty_off, o_full_off;
  logic [17:0] i_wr_data, o_rd_data, rd_d;
  logic [4:0]  o_mem_count;
  logic        o_wr_ready, o_rd_valid, o_busy, o_pae_n, o_paf_n, o_serial_mode, o_first_word_fall_through_mode;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cycles = 0;
  ffl_link_if lnk ();
  ffl_device_end ffl_device_end_inst (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk), .o_empty_off(o_empty_off),
    .o_full_off(o_full_off), .o_mem_count(o_mem_count), .o_serial_mode(o_serial_mode), .o_first_word_fall_through_mode(o_first_word_fall_through_mode));
  ffl_ctrl_end ffl_ctrl_end_inst (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk), .i_mreset(i_mreset),
    .i_serial_sel(i_serial_sel), .i_x9(i_x9), .i_depth(i_depth), .i_first_word_fall_through(i_first_word_fall_through), .i_load(i_load),
    .i_empty_off(i_empty_off), .i_full_off(i_full_off), .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data),
    .o_wr_ready(o_wr_ready), .i_rd(i_rd), .i_offrd(i_offrd), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_busy(o_busy), .o_pae_n(o_pae_n), .o_paf_n(o_paf_n));
  ffl_link_sva ffl_link_sva_inst (.i_clk(i_clk), .i_rst(i_rst), .load_select_n(lnk.load_select_n),
    .serial_shift_enable_n(lnk.serial_shift_enable_n), .write_enable_n(lnk.write_enable_n),
    .read_enable_n(lnk.read_enable_n), .master_reset(lnk.master_reset), .serial_prog_sel(lnk.serial_prog_sel),
    .width_x9_x9(lnk.width_x9_x9), .depth_sel(lnk.depth_sel), .data_out_valid(lnk.data_out_valid),
    .prog_almost_empty_flag_n(lnk.prog_almost_empty_flag_n),
    .prog_almost_full_flag_n(lnk.prog_almost_full_flag_n), .flags_valid(lnk.flags_valid));
  always #50 i_clk = ~i_clk;
  // Cuts a hang short; the whole run needs a few hundred cycles
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end
  task wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task chk_w(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_w
  task chk_b(input logic got, input logic exp);
    chk_w({17'h0, got}, {17'h0, exp});
  endtask : chk_b
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc
  // Master reset request with the config it latches
  task cfg(input logic ser, input logic x9, input logic [2:0] dep, input logic fw);
    @(posedge i_clk);
    {i_mreset, i_serial_sel, i_x9, i_depth, i_first_word_fall_through} <= {1'b1, ser, x9, dep, fw};
    @(posedge i_clk);
    i_mreset <= 1'b0;
    cyc(4);
  endtask : cfg
  task load(input logic [16:0] e, input logic [16:0] f);
    @(posedge i_clk);
    {i_load, i_empty_off, i_full_off} <= {1'b1, e, f};
    @(posedge i_clk);
    i_load <= 1'b0;
  endtask : load
  // Word is taken at the edge where ready is seen high
  task wr(input logic [17:0] d);
    @(posedge i_clk);
    {i_wr_valid, i_wr_data} <= {1'b1, d};
    @(posedge i_clk);
    while (o_wr_ready !== 1'b1) @(posedge i_clk);
    i_wr_valid <= 1'b0;
  endtask : wr
  task done();
    cyc(2);
    while (o_busy !== 1'b0 || lnk.flags_valid !== 1'b1) @(posedge i_clk);
    cyc(2);
  endtask : done
  task rd(input logic off);
    @(posedge i_clk);
    {i_offrd, i_rd} <= {off, !off};
    @(posedge i_clk);
    {i_offrd, i_rd} <= 2'h0;
    while (o_rd_valid !== 1'b1) @(posedge i_clk);
    rd_d = o_rd_data;
  endtask : rd
  task t_reset();
    cyc(2);
    chk_w({1'b0, o_empty_off}, 18'h0007F);
    chk_b(o_serial_mode, 1'b1);
    chk_b(o_pae_n, 1'b0);
    chk_b(o_paf_n, 1'b0);
  endtask : t_reset
  // Full serial load with memory writes cut in between bits
  task t_load(input logic x9, input logic [2:0] dep, input logic fw, input logic [16:0] e, input logic [16:0] f);
    cfg(1'b1, x9, dep, fw);
    load(e, f);
    wr(18'h2A5A5);
    wr(18'h15A5A);
    done();
    chk_w({1'b0, o_empty_off}, {1'b0, e});
    chk_w({1'b0, o_full_off}, {1'b0, f});
    chk_w({13'h0, o_mem_count}, 18'h00002);
    chk_b(o_first_word_fall_through_mode, fw);
    rd(1'b1);
    chk_w(rd_d, {1'b0, e});
    rd(1'b1);
    chk_w(rd_d, {1'b0, f});
  endtask : t_load
  task t_flags();
    cfg(1'b1, 1'b1, 3'h0, 1'b0);
    wr(18'h01111);
    wr(18'h02222);
    wr(18'h03333);
    load(17'h00002, 17'h00003);
    done();
    chk_b(o_pae_n, 1'b1);
    chk_b(o_paf_n, 1'b1);
    rd(1'b0);
    chk_w(rd_d, 18'h01111);
    cyc(4);
    chk_b(o_pae_n, 1'b0);
  endtask : t_flags
  // Parallel method: shifts refused, readback still works
  task t_parallel();
    cfg(1'b0, 1'b1, 3'h3, 1'b0);
    chk_b(o_serial_mode, 1'b0);
    load(17'h00005, 17'h00006);
    done();
    chk_w({1'b0, o_full_off}, 18'h0007F);
    rd(1'b1);
    chk_w(rd_d, 18'h0007F);
    @(posedge i_clk);
    i_serial_sel <= 1'b1;
    cyc(4);
    chk_b(o_serial_mode, 1'b0);
  endtask : t_parallel
  initial begin
    {i_mreset, i_serial_sel, i_x9, i_first_word_fall_through, i_load, i_wr_valid, i_rd, i_offrd} = 8'h00;
    {i_depth, i_empty_off, i_full_off, i_wr_data} = 55'h0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_load(1'b1, 3'h0, 1'b0, 17'h002A5, 17'h0015A);
    t_load(1'b1, 3'h7, 1'b1, 17'h1A5C3, 17'h0E53C);
    t_load(1'b0, 3'h0, 1'b1, 17'h0016B, 17'h00094);
    t_load(1'b0, 3'h7, 1'b0, 17'h0A5C3, 17'h05A3C);
    t_flags();
    t_parallel();
    wrap_up();
  end
endmodule : tb
